// ==== design/i2r_pkg.sv ====
// Constants and types for the I2C register read slave.
// Assumes one core clock and an I2C bus with external pull-ups on both lines.
// Overview of operation
// - Opcode 100b in command byte 0 bits 2:0 requests a register read.
// - Port index is command byte 1 bit 0 (upper) and byte 2 bit 7.
// - Command byte 2 bits 5:2 form the byte lane mask, bit 2 lowest lane.
// - Mask bit one lets that register byte change; zero leaves it unchanged.
// - Byte address is byte 2 bits 1:0, then byte 3, then two zero bits.
// - First packet is START, address with write bit, four acknowledged command bytes.
// - Second packet is START, address with read bit, acknowledge, data bytes, STOP.
// - Data bytes leave register byte 3 first and byte 0 last.
// - With straps at zero the slave answers address 38h, wire bytes 70h/71h.
// - A completed read command fetches the register into a 32-bit holding buffer.
// - Reading past four bytes repeats the sequence starting from byte 3.
// - A repeated START may replace the STOP between the two packets.
package i2r_pkg;
	localparam logic [6:0] SLV_ADDR_BASE = 7'h38;
	localparam int         STRAP_W       = 3;
	localparam logic [2:0] OP_READ       = 3'h4;
	localparam int         OP_MSB        = 2;
	localparam int         OP_LSB        = 0;
	localparam int         PS_HI_BIT     = 0;
	localparam int         PS_LO_BIT     = 7;
	localparam int         BE_MSB        = 5;
	localparam int         BE_LSB        = 2;
	localparam int         AH_MSB        = 1;
	localparam int         AH_LSB        = 0;
	localparam logic [3:0] CNT_ACK       = 4'h8;
	localparam logic [3:0] CNT_END       = 4'h9;
	localparam logic [2:0] CMD_BYTES     = 3'h4;
	localparam logic [1:0] LAST_CMD      = 2'h3;
	localparam logic [1:0] FIRST_TX      = 2'h3;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_TX, PH_SKIP} i2r_phase_t;

	typedef struct packed {
		logic        req;
		logic [1:0]  port;
		logic [11:0] addr;
		logic [3:0]  be;
	} i2r_fetch_t;

	typedef struct packed {
		logic               scl_s1;
		logic               scl_s2;
		logic               scl_d;
		logic               sda_s1;
		logic               sda_s2;
		logic               sda_d;
		logic [STRAP_W-1:0] strap_s1;
		logic [STRAP_W-1:0] strap_s2;
		i2r_phase_t         ph;
		logic [3:0]         cnt;
		logic [7:0]         sh;
		logic [7:0]         tx;
		logic [2:0]         cidx;
		logic [3:0][7:0]    cmd;
		logic [1:0]         sel;
		logic               nak;
		logic               rd;
		logic [31:0]        hold;
		logic               oe;
		logic               sdo;
		i2r_fetch_t         fetch;
	} i2r_state_t;

	localparam i2r_state_t STATE_RST = '0;
endpackage

// ==== design/i2r_read_slave.sv ====
// I2C slave that takes a four-byte read command and returns one 32-bit register.
// Assumes the register fabric answers fetch.req with fetch_ack and fetch_data on clk.
`timescale 1ns/1ns
module i2r_read_slave (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      scl_i,
	input  wire logic                      sda_i,
	output wire logic                      sda_o,
	output wire logic                      sda_oe,
	input  wire logic [i2r_pkg::STRAP_W-1:0] strap_i,
	output wire i2r_pkg::i2r_fetch_t       fetch,
	input  wire logic                      fetch_ack,
	input  wire logic [31:0]               fetch_data
);
	logic [1:0]          rst_q;
	logic                rst_n;
	i2r_pkg::i2r_state_t s_r;
	i2r_pkg::i2r_state_t s_nxt;
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;
	logic                addr_hit;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// Edges are taken from the second synchroniser stage and its delayed copy only.
	assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
	assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
	assign bus_start = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
	assign bus_stop  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
	assign addr_hit  = s_r.sh[7:1] == (i2r_pkg::SLV_ADDR_BASE | {4'h0, s_r.strap_s2});

	always_comb begin
		logic [1:0] nsel;
		logic [7:0] nb;
		nsel = s_r.sel - 2'h1;
		nb = s_r.hold[{nsel, 3'h0} +: 8];
		s_nxt = s_r;
		s_nxt.scl_s1 = scl_i;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_d = s_r.scl_s2;
		s_nxt.sda_s1 = sda_i;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_d = s_r.sda_s2;
		s_nxt.strap_s1 = strap_i;
		s_nxt.strap_s2 = s_r.strap_s1;

		if (s_r.fetch.req && fetch_ack) begin
			s_nxt.fetch.req = 1'b0;
			s_nxt.hold = fetch_data;
		end

		if (bus_start) begin
			// A repeated START restarts address decode from any phase.
			s_nxt.ph = i2r_pkg::PH_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end else if (bus_stop) begin
			s_nxt.ph = i2r_pkg::PH_IDLE;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end else if (s_r.ph != i2r_pkg::PH_IDLE && s_r.ph != i2r_pkg::PH_SKIP) begin
			if (scl_rise) begin
				if (s_r.cnt < i2r_pkg::CNT_ACK) begin
					s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
					s_nxt.cnt = s_r.cnt + 4'h1;
				end else if (s_r.cnt == i2r_pkg::CNT_ACK) begin
					s_nxt.cnt = i2r_pkg::CNT_END;
					s_nxt.nak = s_r.sda_s2;
				end
			end else if (scl_fall) begin
				if (s_r.cnt == i2r_pkg::CNT_ACK) begin
					// Data phase releases the line here so the master can acknowledge.
					s_nxt.oe = 1'b0;
					case (s_r.ph)
						i2r_pkg::PH_ADDR: begin
							s_nxt.oe = addr_hit;
							s_nxt.rd = s_r.sh[0];
							if (!addr_hit) begin
								s_nxt.ph = i2r_pkg::PH_SKIP;
							end
						end
						i2r_pkg::PH_CMD: begin
							if (s_r.cidx == i2r_pkg::CMD_BYTES) begin
								s_nxt.ph = i2r_pkg::PH_SKIP;
							end else begin
								s_nxt.oe = 1'b1;
								s_nxt.cmd[s_r.cidx[1:0]] = s_r.sh;
								s_nxt.cidx = s_r.cidx + 3'h1;
								if (s_r.cidx[1:0] == i2r_pkg::LAST_CMD &&
								    s_r.cmd[0][i2r_pkg::OP_MSB:i2r_pkg::OP_LSB] == i2r_pkg::OP_READ) begin
									s_nxt.fetch.req = 1'b1;
									s_nxt.fetch.port = {s_r.cmd[1][i2r_pkg::PS_HI_BIT],
									                    s_r.cmd[2][i2r_pkg::PS_LO_BIT]};
									// The mask goes to the fabric, which alone may alter register bytes.
									s_nxt.fetch.be = s_r.cmd[2][i2r_pkg::BE_MSB:i2r_pkg::BE_LSB];
									s_nxt.fetch.addr = {s_r.cmd[2][i2r_pkg::AH_MSB:i2r_pkg::AH_LSB],
									                    s_r.sh, 2'h0};
								end
							end
						end
						default: begin
						end
					endcase
				end else if (s_r.cnt == i2r_pkg::CNT_END) begin
					s_nxt.cnt = 4'h0;
					s_nxt.oe = 1'b0;
					if (s_r.ph == i2r_pkg::PH_ADDR && s_r.rd) begin
						s_nxt.ph = i2r_pkg::PH_TX;
						s_nxt.sel = i2r_pkg::FIRST_TX;
						s_nxt.oe = ~s_r.hold[31];
						s_nxt.tx = {s_r.hold[30:24], 1'b1};
					end else if (s_r.ph == i2r_pkg::PH_ADDR) begin
						s_nxt.ph = i2r_pkg::PH_CMD;
						s_nxt.cidx = 3'h0;
					end else if (s_r.ph == i2r_pkg::PH_TX) begin
						if (s_r.nak) begin
							s_nxt.ph = i2r_pkg::PH_SKIP;
						end else begin
							// The two-bit select wraps from byte 0 back to byte 3.
							s_nxt.sel = nsel;
							s_nxt.oe = ~nb[7];
							s_nxt.tx = {nb[6:0], 1'b1};
						end
					end
				end else if (s_r.ph == i2r_pkg::PH_TX) begin
					s_nxt.oe = ~s_r.tx[7];
					s_nxt.tx = {s_r.tx[6:0], 1'b1};
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= i2r_pkg::STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sda_o  = s_r.sdo;
	assign sda_oe = s_r.oe;
	assign fetch  = s_r.fetch;

	default clocking dflt_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_read_opcode: assert property ($rose(s_r.fetch.req) |->
		s_r.cmd[0][i2r_pkg::OP_MSB:i2r_pkg::OP_LSB] == i2r_pkg::OP_READ)
		else $error("Fetch issued without read opcode.");

	a_port_index: assert property ($rose(s_r.fetch.req) |->
		s_r.fetch.port == {s_r.cmd[1][0], s_r.cmd[2][7]})
		else $error("Port index built from wrong bits.");

	a_lane_mask: assert property ($rose(s_r.fetch.req) |-> s_r.fetch.be == s_r.cmd[2][5:2])
		else $error("Byte lane mask taken from wrong bits.");

	a_mask_hold: assert property (s_r.fetch.req && !fetch_ack |=> $stable(s_r.fetch.be))
		else $error("Byte lane mask changed during fetch.");

	a_addr_form: assert property ($rose(s_r.fetch.req) |->
		s_r.fetch.addr == {s_r.cmd[2][1:0], s_r.cmd[3], 2'h0})
		else $error("Register byte address formed wrongly.");

	a_addr_ack: assert property (s_r.ph == i2r_pkg::PH_ADDR && scl_fall && s_r.cnt == 4'h8 &&
		s_r.strap_s2 == 3'h0 && s_r.sh[7:1] == 7'h38 |=> s_r.oe ##1 s_r.oe)
		else $error("Own address not acknowledged.");

	a_cmd_ack: assert property (s_r.ph == i2r_pkg::PH_CMD && scl_fall && s_r.cnt == 4'h8 &&
		s_r.cidx < 3'h4 |=> s_r.oe && s_r.cidx == $past(s_r.cidx) + 3'h1)
		else $error("Command byte not acknowledged.");

	a_tx_first: assert property (s_r.ph == i2r_pkg::PH_ADDR && scl_fall && s_r.cnt == 4'h9 &&
		s_r.rd |=> s_r.ph == i2r_pkg::PH_TX && s_r.sel == 2'h3)
		else $error("Read data phase did not start at byte 3.");

	a_tx_order: assert property (s_r.ph == i2r_pkg::PH_TX && scl_fall && s_r.cnt == 4'h9 &&
		!s_r.nak |=> s_r.sel == $past(s_r.sel) - 2'h1)
		else $error("Data byte order broken.");

	a_hold_load: assert property (s_r.fetch.req && fetch_ack |=>
		s_r.hold == $past(fetch_data) && !s_r.fetch.req)
		else $error("Holding buffer not loaded from fetch.");

	a_restart: assert property (bus_start |=> s_r.ph == i2r_pkg::PH_ADDR && !s_r.oe && s_r.cnt == 4'h0)
		else $error("Repeated START not honoured.");
endmodule

// ==== sim/i2r_master_model.sv ====
// I2C bus master model with start, stop and byte tasks.
// Assumes the bench resolves SDA from sda_lo and the slave's enable, pulled up.
`timescale 1ns/1ns
module i2r_master_model (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_lo
);
	// Called once by the bench at time zero, so SCL starts high and SDA starts released.
	task automatic idle();
		scl = 1'b1;
		sda_lo = 1'b0;
	endtask
	task automatic q();
		repeat (5) @(negedge clk);
	endtask
	// SDA moves only mid-way through SCL low, so no false START or STOP appears.
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_lo = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
	endtask
	task automatic start();
		q();
		sda_lo = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_lo = 1'b1;
		q();
		scl = 1'b0;
	endtask
	task automatic stop();
		q();
		sda_lo = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_lo = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack_n);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule

// ==== sim/i2r_read_slave_tb_top.sv ====
// Testbench for the I2C register read slave with a delayed register fabric.
// Assumes straps at zero and the master model driving SCL and SDA.
`timescale 1ns/1ns
module i2r_read_slave_tb_top;
	logic                clk, rst_b, fetch_ack, scl, sda_lo, sda_o, sda_oe, sda, an;
	logic [31:0]         fetch_data, exp_d;
	logic [7:0]          rd, b2, a3;
	logic [3:0]          be;
	logic [1:0]          ps;
	i2r_pkg::i2r_fetch_t fetch, cap;
	int                  failures = 0, checks = 0, nf = 0, ack_wait = 0;

	assign sda = ~(sda_lo | sda_oe);
	assign fetch_data = 32'h8c4e1a70 + 32'(fetch.port);

	i2r_master_model u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
	i2r_read_slave u_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .strap_i(3'h0), .fetch(fetch), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// The fabric answers three cycles late, so a waiting request is seen by the design.
	always @(negedge clk) begin
		ack_wait <= (fetch.req && !fetch_ack) ? ack_wait + 1 : 0;
		fetch_ack <= fetch.req && !fetch_ack && ack_wait == 2;
	end
	always @(posedge clk) begin
		if (fetch.req && fetch_ack) nf <= nf + 1;
		if (fetch.req) cap <= fetch;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] d);
		u_mst.wbyte(d, an);
		chk(32'(an), 32'h0);
		chk(32'(sda_o), 32'h0);
	endtask
	task automatic give_verdict();
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		u_mst.idle();
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (10) @(negedge clk);
		for (int p = 0; p < 4; p++) begin
			ps = 2'(p);
			be = (p == 0) ? 4'hf : 4'h1 << p;
			b2 = {ps[0], 1'b0, be, ps};
			a3 = 8'h2d + 8'(p);
			u_mst.start();
			send(8'h70);
			send(8'h04);
			send({7'h0, ps[1]});
			send(b2);
			send(a3);
			chk(32'(nf), 32'(p + 1));
			chk(32'(cap), 32'({1'b1, ps, ps, a3, 2'h0, be}));
			// Only the first pass stops; the rest use a repeated START.
			if (p == 0) u_mst.stop();
			u_mst.start();
			send(8'h71);
			exp_d = 32'h8c4e1a70 + 32'(p);
			for (int k = 0; k < 5; k++) begin
				u_mst.rbyte(k == 4, rd);
				chk(32'(rd), 32'(exp_d[8*(3-k%4) +: 8]));
			end
			u_mst.stop();
		end
		u_mst.start();
		send(8'h70);
		send(8'h03);
		send(8'h00);
		send(8'h3c);
		send(8'h2d);
		// A fifth command byte is refused with a NAK.
		u_mst.wbyte(8'h00, an);
		chk(32'(an), 32'h1);
		repeat (20) @(negedge clk);
		chk(32'(nf), 32'h4);
		u_mst.start();
		u_mst.wbyte(8'h72, an);
		chk(32'(an), 32'h1);
		u_mst.stop();
		give_verdict();
	end

	// The full run needs about 9500 cycles, so this limit leaves ample margin.
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
